//--- pkg/tcc_pkg.sv
package tcc_pkg;
	// bus geometry
	localparam int unsigned AW = 5;
	localparam int unsigned DW = 32;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned NCH = 3;
	// channel slots inside arrays
	localparam int unsigned CH_B = 0;
	localparam int unsigned CH_C = 1;
	localparam int unsigned CH_D = 2;
	// register byte offsets
	localparam logic [AW-1:0] OFS_B_CTRL = 5'h00;
	localparam logic [AW-1:0] OFS_CD_CTRL = 5'h04;
	localparam logic [AW-1:0] OFS_MODE = 5'h08;
	localparam logic [NCH-1:0][AW-1:0] OFS_GEN = {5'h14, 5'h10, 5'h0c};
	localparam logic [AW-1:0] OFS_STATUS = 5'h18;
	// control code fields and values
	localparam int unsigned CTRL_CAP_BIT = 3;
	localparam int unsigned CTRL_SRC_BIT = 2;
	localparam int unsigned CTRL_BOTH_BIT = 1;
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_CLR = 2'h1;
	localparam logic [1:0] ACT_SET = 2'h2;
	localparam logic [1:0] ACT_TGL = 2'h3;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [2:0] PSC_UNDIV = 3'h0;
	// reset values
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [CNT_W-1:0] GEN_RST = 16'h0000;

	typedef enum logic [2:0] {FN_OFF, FN_OC, FN_CAP_PIN, FN_CAP_CH4, FN_IDLE} tcc_fn_t;

	typedef struct packed {
		logic [AW-1:0] address;
		logic read;
		logic write;
		logic [DW-1:0] writedata;
		logic [DW/BYTE_W-1:0] byteenable;
	} tcc_avreq_t;

	typedef struct packed {
		logic out;
		logic oe_n;
	} tcc_pin_t;

	typedef struct packed {
		logic [3:0] d;
		logic [3:0] c;
	} tcc_cd_t;

	typedef struct packed {
		logic [2:0] ch4_prescale_sel;
		logic buffer_mode_b;
		logic buffer_mode_a;
	} tcc_mode_t;

	typedef struct packed {
		tcc_pin_t d;
		tcc_pin_t c;
		tcc_pin_t b;
	} tcc_stat_t;

	localparam tcc_cd_t CD_RST = 8'h00;
	localparam tcc_mode_t MODE_RST = 5'h00;
endpackage : tcc_pkg

//--- design/tcc_chan.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_chan (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [3:0] ctrl,
	input wire logic ctrl_wr,
	input wire logic blocked,
	input wire logic ch4_ok,
	input wire logic ch4_evt,
	input wire logic [tcc_pkg::CNT_W-1:0] count,
	input wire logic [tcc_pkg::CNT_W-1:0] gen_val,
	input wire logic pin_in,
	output tcc_pkg::tcc_pin_t pin,
	output logic cap
);
	import tcc_pkg::*;

	logic sync1_r, sync2_r, last_r, level_r, oe_n_r, mlast_r;
	logic sync1_nxt, sync2_nxt, last_nxt, level_nxt, oe_n_nxt, mlast_nxt;
	logic rise, fall, match, match_evt, trig;
	tcc_fn_t fn;

	// buffer use overrides whatever the code says
	always_comb begin
		if (blocked)
			fn = FN_IDLE;
		else if (!ctrl[CTRL_CAP_BIT])
			fn = (ctrl[1:0] == ACT_OFF) ? FN_OFF : FN_OC;
		else if (!ctrl[CTRL_SRC_BIT])
			fn = FN_CAP_PIN;
		else
			fn = FN_CAP_CH4;
	end

	// edges only from the second sync stage and its delayed copy
	assign rise = sync2_r & ~last_r;
	assign fall = ~sync2_r & last_r;
	assign match = (count == gen_val);
	// a stalled counter would otherwise re-fire the match every cycle
	assign match_evt = match & ~mlast_r;

	// capture trigger per function
	always_comb begin
		trig = 1'b0;
		unique case (fn)
			FN_CAP_PIN: begin
				if (ctrl[CTRL_BOTH_BIT])
					trig = rise | fall;
				else if (ctrl[1:0] == EDGE_FALL)
					trig = fall;
				else
					trig = rise;
			end
			FN_CAP_CH4: trig = ch4_evt & ch4_ok;
			FN_OFF, FN_OC, FN_IDLE: trig = 1'b0;
		endcase
	end
	assign cap = ce & trig;

	// next pin and sampler state
	always_comb begin
		sync1_nxt = pin_in;
		sync2_nxt = sync1_r;
		last_nxt = sync2_r;
		mlast_nxt = match;
		level_nxt = level_r;
		oe_n_nxt = (fn != FN_OC);
		if (ctrl_wr && !ctrl[CTRL_CAP_BIT] && !blocked)
			level_nxt = ctrl[CTRL_SRC_BIT];
		else if (fn == FN_OC && match_evt) begin
			unique case (ctrl[1:0])
				ACT_CLR: level_nxt = 1'b0;
				ACT_SET: level_nxt = 1'b1;
				ACT_TGL: level_nxt = ~level_r;
				ACT_OFF: level_nxt = level_r;
			endcase
		end
	end

	// state frozen while the clock enable is low
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			last_r <= 1'b0;
			mlast_r <= 1'b0;
			level_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else if (ce) begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			last_r <= last_nxt;
			mlast_r <= mlast_nxt;
			level_r <= level_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign pin.out = level_r;
	assign pin.oe_n = oe_n_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_code_write;
		ce && ctrl_wr && !ctrl[CTRL_CAP_BIT] && !blocked;
	endsequence
	sequence s_oc_match(logic [1:0] act);
		ce && fn == FN_OC && ctrl[1:0] == act && match_evt && !ctrl_wr;
	endsequence

	a_oc_disabled: assert property (ce && fn == FN_OFF |=> oe_n_r && !cap)
		else $error("disabled compare output is driven");
	a_match_clear: assert property (s_oc_match(ACT_CLR) |=> !level_r ##1
		($stable(level_r) || $past(ctrl_wr) || $past(match_evt)))
		else $error("clear on match failed");
	a_match_set: assert property (s_oc_match(ACT_SET) |=> level_r)
		else $error("set on match failed");
	a_match_toggle: assert property (s_oc_match(ACT_TGL) |=> level_r != $past(level_r))
		else $error("toggle on match failed");
	a_pin_source: assert property (cap && fn == FN_CAP_PIN |-> sync2_r != last_r)
		else $error("pin capture without a pin edge");
	a_cap_rise: assert property (ce && fn == FN_CAP_PIN && ctrl[1:0] == EDGE_RISE |-> cap == rise)
		else $error("rising edge capture wrong");
	a_cap_fall: assert property (ce && fn == FN_CAP_PIN && ctrl[1:0] == EDGE_FALL |-> cap == fall)
		else $error("falling edge capture wrong");
	a_cap_both: assert property (ce && fn == FN_CAP_PIN && ctrl[CTRL_BOTH_BIT] |-> cap == (rise || fall))
		else $error("both edge capture wrong");
	a_ch4_capture: assert property (ce && fn == FN_CAP_CH4 && ch4_ok |-> cap == ch4_evt)
		else $error("channel 4 count capture wrong");
	a_psc_block: assert property (fn == FN_CAP_CH4 && !ch4_ok |-> !cap)
		else $error("capture on undivided clock");
	a_buffer_quiet: assert property (blocked |-> !cap ##1 (oe_n_r || !$past(ce)))
		else $error("buffer register active");
	a_init_level: assert property (s_code_write |=> level_r == $past(ctrl[CTRL_SRC_BIT]))
		else $error("initial level not applied");
endmodule : tcc_chan
`default_nettype wire

//--- design/tcc_ch3_io_ctrl.sv
// Operation
// - a code with bit 3 clear is output compare, bit 2 gives the initial level, low bits 00 leave the pin undriven.
// - compare with low bits 01 drives the pin low on a counter match.
// - compare with low bits 10 drives the pin high on a counter match.
// - compare with low bits 11 inverts the pin on every counter match.
// - bits 3 and 2 equal to 10 make the register capture from its own channel 3 pin.
// - pin capture with low bits 00 captures on a rising edge.
// - pin capture with low bits 01 captures on a falling edge.
// - pin capture with bit 1 set captures on both edges.
// - bits 3 and 2 both set capture on every channel 4 count, low bits ignored.
// - for registers b and d the channel 4 count capture never fires while the channel 4 prescaler selects 000.
// - while buffer mode a is set register c neither captures nor compares.
// - while buffer mode b is set register d neither captures nor compares.
// - a register used as a buffer acts only as a buffer, whatever its code.
// - each capture event copies the counter into the capturing register.
`timescale 1ns/1ps
`default_nettype none
module tcc_ch3_io_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire tcc_pkg::tcc_avreq_t avs_req,
	output logic avs_waitrequest,
	output logic [tcc_pkg::DW-1:0] avs_readdata,
	input wire logic [tcc_pkg::CNT_W-1:0] ch3_count,
	input wire logic ch4_count_evt,
	input wire logic ch3_pin_b_in,
	input wire logic ch3_pin_c_in,
	input wire logic ch3_pin_d_in,
	output tcc_pkg::tcc_pin_t ch3_pin_b,
	output tcc_pkg::tcc_pin_t ch3_pin_c,
	output tcc_pkg::tcc_pin_t ch3_pin_d
);
	import tcc_pkg::*;

	logic [3:0] b_ctrl_r, b_ctrl_nxt;
	tcc_cd_t cd_ctrl_r, cd_ctrl_nxt;
	tcc_mode_t mode_r, mode_nxt;
	logic [CNT_W-1:0] gen_r [NCH];
	logic [CNT_W-1:0] gen_nxt [NCH];
	logic [NCH-1:0] wr_r, wr_nxt;
	logic ack_r, ack_nxt;
	logic [DW-1:0] rdata_r, rdata_nxt, rd_val;
	logic acc, wr_go, rd_load;
	logic [3:0] ctrl [NCH];
	logic [NCH-1:0] blocked, ch4_ok, cap, pin_in;
	tcc_pin_t pin [NCH];
	tcc_stat_t stat;

	// byte-lane merge for the 16-bit general registers
	function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old, input logic [DW-1:0] wd,
		input logic [DW/BYTE_W-1:0] be);
		logic [CNT_W-1:0] m;
		m = old;
		for (int i = 0; i < CNT_W / BYTE_W; i++) begin
			if (be[i])
				m[i*BYTE_W +: BYTE_W] = wd[i*BYTE_W +: BYTE_W];
		end
		return m;
	endfunction : merge

	// one wait state per access; a frozen clock enable keeps the bus waiting
	assign acc = avs_req.read | avs_req.write;
	assign avs_waitrequest = acc & ~(ack_r & ce);
	assign wr_go = avs_req.write & ack_r & ce;
	assign rd_load = avs_req.read & ~ack_r;
	assign ack_nxt = acc & ~ack_r;

	// channel wiring
	assign ctrl[CH_B] = b_ctrl_r;
	assign ctrl[CH_C] = cd_ctrl_r.c;
	assign ctrl[CH_D] = cd_ctrl_r.d;
	assign blocked[CH_B] = 1'b0;
	assign blocked[CH_C] = mode_r.buffer_mode_a;
	assign blocked[CH_D] = mode_r.buffer_mode_b;
	// undivided channel 4 clock voids count capture on b and d only
	assign ch4_ok[CH_B] = (mode_r.ch4_prescale_sel != PSC_UNDIV);
	assign ch4_ok[CH_C] = 1'b1;
	assign ch4_ok[CH_D] = (mode_r.ch4_prescale_sel != PSC_UNDIV);
	assign pin_in = {ch3_pin_d_in, ch3_pin_c_in, ch3_pin_b_in};

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_chan
			tcc_chan u_chan (
				.core_clk(core_clk),
				.rst(rst),
				.ce(ce),
				.ctrl(ctrl[g]),
				.ctrl_wr(wr_r[g]),
				.blocked(blocked[g]),
				.ch4_ok(ch4_ok[g]),
				.ch4_evt(ch4_count_evt),
				.count(ch3_count),
				.gen_val(gen_r[g]),
				.pin_in(pin_in[g]),
				.pin(pin[g]),
				.cap(cap[g])
			);
		end
	endgenerate

	assign ch3_pin_b = pin[CH_B];
	assign ch3_pin_c = pin[CH_C];
	assign ch3_pin_d = pin[CH_D];
	assign stat.b = pin[CH_B];
	assign stat.c = pin[CH_C];
	assign stat.d = pin[CH_D];

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_val = '0;
		unique case (avs_req.address)
			OFS_B_CTRL: rd_val = DW'(b_ctrl_r);
			OFS_CD_CTRL: rd_val = DW'(cd_ctrl_r);
			OFS_MODE: rd_val = DW'(mode_r);
			OFS_GEN[CH_B]: rd_val = DW'(gen_r[CH_B]);
			OFS_GEN[CH_C]: rd_val = DW'(gen_r[CH_C]);
			OFS_GEN[CH_D]: rd_val = DW'(gen_r[CH_D]);
			OFS_STATUS: rd_val = DW'(stat);
			default: rd_val = '0;
		endcase
	end

	// register next values; a capture beats a bus write in the same cycle
	always_comb begin
		b_ctrl_nxt = b_ctrl_r;
		cd_ctrl_nxt = cd_ctrl_r;
		mode_nxt = mode_r;
		wr_nxt = '0;
		rdata_nxt = rd_load ? rd_val : rdata_r;
		for (int i = 0; i < NCH; i++) begin
			gen_nxt[i] = gen_r[i];
			if (wr_go && avs_req.address == OFS_GEN[i])
				gen_nxt[i] = merge(gen_r[i], avs_req.writedata, avs_req.byteenable);
			if (cap[i])
				gen_nxt[i] = ch3_count;
		end
		if (wr_go && avs_req.byteenable[0]) begin
			if (avs_req.address == OFS_B_CTRL) begin
				b_ctrl_nxt = avs_req.writedata[3:0];
				wr_nxt[CH_B] = 1'b1;
			end
			if (avs_req.address == OFS_CD_CTRL) begin
				cd_ctrl_nxt = avs_req.writedata[$bits(tcc_cd_t)-1:0];
				wr_nxt[CH_C] = 1'b1;
				wr_nxt[CH_D] = 1'b1;
			end
			if (avs_req.address == OFS_MODE)
				mode_nxt = avs_req.writedata[$bits(tcc_mode_t)-1:0];
		end
	end

	// all bus and control state holds while the clock enable is low
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			b_ctrl_r <= CTRL_RST;
			cd_ctrl_r <= CD_RST;
			mode_r <= MODE_RST;
			wr_r <= '0;
			ack_r <= 1'b0;
			rdata_r <= '0;
			for (int i = 0; i < NCH; i++)
				gen_r[i] <= GEN_RST;
		end else if (ce) begin
			b_ctrl_r <= b_ctrl_nxt;
			cd_ctrl_r <= cd_ctrl_nxt;
			mode_r <= mode_nxt;
			wr_r <= wr_nxt;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			for (int i = 0; i < NCH; i++)
				gen_r[i] <= gen_nxt[i];
		end
	end

	assign avs_readdata = rdata_r;

	a_capture_load: assert property (@(posedge core_clk) disable iff (rst)
		cap[CH_B] |=> gen_r[CH_B] == $past(ch3_count))
		else $error("captured count not stored");
	a_buffer_c_quiet: assert property (@(posedge core_clk) disable iff (rst)
		mode_r.buffer_mode_a |-> !cap[CH_C])
		else $error("register c active in buffer mode");
	a_buffer_d_quiet: assert property (@(posedge core_clk) disable iff (rst)
		mode_r.buffer_mode_b |-> !cap[CH_D])
		else $error("register d active in buffer mode");
	a_reset_codes: assert property (@(posedge core_clk)
		rst |=> b_ctrl_r == CTRL_RST && cd_ctrl_r == CD_RST)
		else $error("codes not zero after reset");
	// the same load for the other two capture slots
	a_capture_load_c: assert property (@(posedge core_clk) disable iff (rst)
		cap[CH_C] |=> gen_r[CH_C] == $past(ch3_count))
		else $error("captured count not stored in c");
	a_capture_load_d: assert property (@(posedge core_clk) disable iff (rst)
		cap[CH_D] |=> gen_r[CH_D] == $past(ch3_count))
		else $error("captured count not stored in d");
	// a buffered register must let go of its pin as well
	a_buffer_c_pin: assert property (@(posedge core_clk) disable iff (rst)
		ce && mode_r.buffer_mode_a |=> ch3_pin_c.oe_n)
		else $error("register c drives its pin in buffer mode");
	a_buffer_d_pin: assert property (@(posedge core_clk) disable iff (rst)
		ce && mode_r.buffer_mode_b |=> ch3_pin_d.oe_n)
		else $error("register d drives its pin in buffer mode");
	// count capture on b and d dies with the undivided channel 4 clock
	a_psc_b_quiet: assert property (@(posedge core_clk) disable iff (rst)
		b_ctrl_r[CTRL_CAP_BIT] && b_ctrl_r[CTRL_SRC_BIT] && mode_r.ch4_prescale_sel == PSC_UNDIV
		|-> !cap[CH_B])
		else $error("register b captured on undivided clock");
	a_psc_d_quiet: assert property (@(posedge core_clk) disable iff (rst)
		cd_ctrl_r.d[CTRL_CAP_BIT] && cd_ctrl_r.d[CTRL_SRC_BIT] && mode_r.ch4_prescale_sel == PSC_UNDIV
		|-> !cap[CH_D])
		else $error("register d captured on undivided clock");
	// c keeps count capture whatever the prescaler says
	a_ch4_c_capture: assert property (@(posedge core_clk) disable iff (rst)
		ce && cd_ctrl_r.c[CTRL_CAP_BIT] && cd_ctrl_r.c[CTRL_SRC_BIT] && !mode_r.buffer_mode_a
		|-> cap[CH_C] == ch4_count_evt)
		else $error("register c count capture wrong");
	// exactly one wait state while the enable stays high
	a_bus_one_wait: assert property (@(posedge core_clk) disable iff (rst)
		ce && acc && avs_waitrequest ##1 ce && acc |-> !avs_waitrequest)
		else $error("bus answer late");
endmodule : tcc_ch3_io_ctrl
`default_nettype wire

//--- bench/tcc_far.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_far (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] cnt_set,
	input wire logic evt_req,
	input wire logic [2:0] lvl,
	input wire tcc_pkg::tcc_stat_t pins,
	output logic [15:0] count,
	output logic ch4_evt,
	output logic [2:0] pin_in
);
	import tcc_pkg::*;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic evt_r;
	logic evt_nxt;
	// counter and count pulse follow the bench one edge late, like a real counter
	always_comb begin
		count_nxt = cnt_set;
		evt_nxt = evt_req;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_r <= 16'h0000;
			evt_r <= 1'h0;
		end else begin
			count_r <= count_nxt;
			evt_r <= evt_nxt;
		end
	end
	assign count = count_r;
	assign ch4_evt = evt_r;
	// wire level: the device wins while it drives, else the outside level
	assign pin_in[0] = pins.b.oe_n ? lvl[0] : pins.b.out;
	assign pin_in[1] = pins.c.oe_n ? lvl[1] : pins.c.out;
	assign pin_in[2] = pins.d.oe_n ? lvl[2] : pins.d.out;
endmodule : tcc_far
`default_nettype wire

//--- bench/test_timer_ch3_capture_compare_io_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer_ch3_capture_compare_io_control;
	import tcc_pkg::*;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	tcc_avreq_t req = '0;
	logic wreq;
	logic [DW-1:0] rdata;
	logic [15:0] cnt_set = 16'h0000;
	logic evt_req = 1'h0;
	logic [2:0] lvl = 3'h0;
	logic [15:0] count;
	logic ch4_evt;
	logic [2:0] pin_in;
	tcc_pin_t pb;
	tcc_pin_t pc;
	tcc_pin_t pd;
	tcc_stat_t pins;
	int n_mismatch = 0;
	int n_compared = 0;
	logic [31:0] q;
	// compare rows: code, then oe_n, initial level, level after 1st and 2nd match
	logic [7:0] oc_rows[8] = '{8'h08, 8'h10, 8'h23, 8'h32, 8'h4c, 8'h54, 8'h67, 8'h75};
	// capture rows: code, then reg value after rising edge, falling edge, ch4 count
	logic [51:0] cap_rows[6] = '{52'h8_1111_1111_1111, 52'h9_0000_2222_2222, 52'ha_1111_2222_2222,
		52'hb_1111_2222_2222, 52'hc_0000_0000_3333, 52'hf_0000_0000_3333};
	assign pins = {pd, pc, pb};
	always #2.5 core_clk = ~core_clk;
	tcc_ch3_io_ctrl i_tcc_ch3_io_ctrl (.core_clk(core_clk), .rst(rst), .ce(ce), .avs_req(req),
		.avs_waitrequest(wreq), .avs_readdata(rdata), .ch3_count(count), .ch4_count_evt(ch4_evt),
		.ch3_pin_b_in(pin_in[0]), .ch3_pin_c_in(pin_in[1]), .ch3_pin_d_in(pin_in[2]),
		.ch3_pin_b(pb), .ch3_pin_c(pc), .ch3_pin_d(pd));
	tcc_far i_tcc_far (.core_clk(core_clk), .rst(rst), .cnt_set(cnt_set), .evt_req(evt_req),
		.lvl(lvl), .pins(pins), .count(count), .ch4_evt(ch4_evt), .pin_in(pin_in));
	task automatic wait_cy(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wait_cy
	// one bus cycle; the request is held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d, output logic [DW-1:0] r);
		@(posedge core_clk);
		req.address <= a;
		req.read <= ~wr;
		req.write <= wr;
		req.writedata <= d;
		req.byteenable <= 4'hf;
		// no cycle limit here: only the watchdog may end a hung access
		do begin
			@(posedge core_clk);
		end while (wreq !== 1'h0);
		r = rdata;
		req.read <= 1'h0;
		req.write <= 1'h0;
	endtask : bus
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk
	// rising edge, falling edge, then a ch4 pulse, each with a fresh counter value
	task automatic cap_run(input int p, input logic [47:0] e);
		logic [31:0] r;
		bus(1'h1, OFS_GEN[p], 32'h0, r);
		for (int j = 0; j < 3; j++) begin
			cnt_set <= 16'(16'h1111 * (j + 1));
			wait_cy(3);
			if (j == 2) evt_req <= 1'h1;
			else lvl[p] <= (j == 0);
			wait_cy(1);
			evt_req <= 1'h0;
			wait_cy(8);
			bus(1'h0, OFS_GEN[p], 32'h0, r);
			chk("gen_cap", {16'h0, e[47-16*j -: 16]}, r);
		end
	endtask : cap_run
	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	// watchdog sized well above the fewer than a thousand cycles the tests need
	initial begin
		wait_cy(20000);
		n_mismatch++;
		test_done;
	end
	initial begin
		logic [7:0] r;
		logic [51:0] c;
		wait_cy(8);
		rst <= 1'h0;
		// reset values and an unmapped read
		bus(1'h0, OFS_B_CTRL, 32'h0, q);
		chk("b_ctrl", 32'h0, q);
		bus(1'h0, OFS_CD_CTRL, 32'h0, q);
		chk("cd_ctrl", 32'h0, q);
		bus(1'h0, OFS_MODE, 32'h0, q);
		chk("mode", 32'h0, q);
		bus(1'h0, OFS_STATUS, 32'h0, q);
		chk("status", 32'h15, q);
		bus(1'h0, 5'h1c, 32'h0, q);
		chk("unmapped", 32'h0, q);
		$display("test reset done");
		bus(1'h1, OFS_GEN[CH_B], 32'h40, q);
		for (int i = 0; i < 8; i++) begin
			r = oc_rows[i];
			bus(1'h1, OFS_B_CTRL, {28'h0, r[7:4]}, q);
			wait_cy(3);
			chk("b_oe_n", r[3], pb.oe_n);
			chk("b_init", r[2], pb.out);
			for (int m = 0; m < 2; m++) begin
				cnt_set <= 16'h0040;
				wait_cy(3);
				if (!r[3]) chk("b_match", r[1-m], pb.out);
				cnt_set <= 16'h0000;
				wait_cy(2);
			end
		end
		$display("test compare done");
		for (int i = 0; i < 6; i++) begin
			c = cap_rows[i];
			bus(1'h1, OFS_CD_CTRL, {28'h0, c[51:48]}, q);
			cap_run(CH_C, c[47:0]);
		end
		$display("test capture done");
		// undivided ch4 clock, then buffer modes that block c and d
		bus(1'h1, OFS_B_CTRL, 32'hc, q);
		cap_run(CH_B, 48'h0);
		bus(1'h1, OFS_CD_CTRL, 32'hc8, q);
		cap_run(CH_D, 48'h0);
		bus(1'h1, OFS_MODE, 32'h04, q);
		cap_run(CH_D, 48'h0000_0000_3333);
		bus(1'h1, OFS_MODE, 32'h05, q);
		cap_run(CH_C, 48'h0);
		bus(1'h1, OFS_MODE, 32'h06, q);
		cap_run(CH_D, 48'h0);
		$display("test blocking done");
		// compare outputs on c and d, with c held off by buffer mode a
		bus(1'h1, OFS_MODE, 32'h05, q);
		bus(1'h1, OFS_CD_CTRL, 32'h56, q);
		wait_cy(3);
		chk("c_oe_n", 32'h1, pc.oe_n);
		chk("d_oe_n", 32'h0, pd.oe_n);
		chk("d_init", 32'h1, pd.out);
		// a low clock enable holds the pin through a match
		ce <= 1'h0;
		cnt_set <= 16'h0000;
		wait_cy(4);
		chk("d_frozen", 32'h1, pd.out);
		ce <= 1'h1;
		wait_cy(3);
		chk("d_clear", 32'h0, pd.out);
		$display("test enable done");
		// reset in mid-run brings every code back to zero
		rst <= 1'h1;
		wait_cy(2);
		rst <= 1'h0;
		bus(1'h0, OFS_CD_CTRL, 32'h0, q);
		chk("cd_ctrl_rst", 32'h0, q);
		bus(1'h0, OFS_STATUS, 32'h0, q);
		chk("status_rst", 32'h15, q);
		$display("test mid reset done");
		test_done;
	end
endmodule : test_timer_ch3_capture_compare_io_control
`default_nettype wire
